// file: snc_cfg.svh
`ifndef SNC_CFG_SVH
`define SNC_CFG_SVH

// Opcodes
`define SNC_OP_RESET 8'hFF
`define SNC_OP_GET_FEAT 8'h0F
`define SNC_OP_SET_FEAT 8'h1F
`define SNC_OP_PAGE_READ 8'h13
`define SNC_OP_CACHE_LAST 8'h3F
`define SNC_OP_RD_X1 8'h03
`define SNC_OP_RD_X1_FAST 8'h0B
`define SNC_OP_RD_X2 8'h3B
`define SNC_OP_RD_X4 8'h6B
`define SNC_OP_RD_DIO 8'hBB
`define SNC_OP_RD_QIO 8'hEB
`define SNC_OP_WR_EN 8'h06
`define SNC_OP_WR_DIS 8'h04
`define SNC_OP_ERASE 8'hD8
`define SNC_OP_PROG_EXEC 8'h10
`define SNC_OP_LOAD_X1 8'h02
`define SNC_OP_LOAD_X4 8'h32
`define SNC_OP_RLOAD_X1 8'h84
`define SNC_OP_RLOAD_X4 8'h34
`define SNC_OP_PERM_LOCK 8'h2C

// Feature addresses
`define SNC_FA_LOCK 8'hA0
`define SNC_FA_CFG 8'hB0
`define SNC_FA_STATUS 8'hC0

// Status byte fields
`define SNC_ST_OIP 0
`define SNC_ST_WEL 1
`define SNC_ST_ECC_LO 4
`define SNC_ST_ECC_HI 5

// Configuration mode field and reset values
`define SNC_CFG_MODE_HI 2
`define SNC_CFG_RST 8'h00
`define SNC_LOCK_RST 8'h00

// Cache geometry and phase lengths in bits
`define SNC_CACHE_BYTES 12'h880
`define SNC_OPC_BITS 5'h08
`define SNC_FA_BITS 5'h08
`define SNC_COL_BITS 5'h10
`define SNC_ROW_BITS 5'h18
`define SNC_DUMMY1_BITS 5'h08
`define SNC_DUMMY2_BITS 5'h10

// Timing
`define SNC_CLK_MHZ 125
`define SNC_T_RD_NS 20000
`define SNC_T_CPY_NS 10000
`define SNC_T_RST_NS 100000
`define SNC_T_PRG_NS 300000
`define SNC_T_ERS_NS 1000000
`define SNC_RD_CYC (`SNC_T_RD_NS * `SNC_CLK_MHZ / 1000)
`define SNC_CPY_CYC (`SNC_T_CPY_NS * `SNC_CLK_MHZ / 1000)
`define SNC_RST_CYC (`SNC_T_RST_NS * `SNC_CLK_MHZ / 1000)
`define SNC_PRG_CYC (`SNC_T_PRG_NS * `SNC_CLK_MHZ / 1000)
`define SNC_ERS_CYC (`SNC_T_ERS_NS * `SNC_CLK_MHZ / 1000)

`endif

// file: snc_pkg.sv
package snc_pkg;

  typedef enum logic [5:0] {
    SNC_ST_OPC   = 6'h01,
    SNC_ST_ADDR  = 6'h02,
    SNC_ST_DUMMY = 6'h04,
    SNC_ST_DIN   = 6'h08,
    SNC_ST_DOUT  = 6'h10,
    SNC_ST_IGN   = 6'h20
  } snc_state_t;

  typedef enum logic [2:0] {
    SNC_ARR_NONE  = 3'h0,
    SNC_ARR_READ  = 3'h1,
    SNC_ARR_PROG  = 3'h2,
    SNC_ARR_ERASE = 3'h3,
    SNC_ARR_LOCK  = 3'h4,
    SNC_ARR_ABORT = 3'h5,
    SNC_ARR_COPY  = 3'h6
  } snc_arr_op_t;

  typedef struct packed {
    logic [7:0] opc;
    logic [23:0] addr;
    logic [7:0] data;
  } snc_evt_t;

  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] cfg;
    logic [7:0] stat;
  } snc_feat_t;

endpackage

// file: snc_decoder.sv
`timescale 1ns/1ps
`include "snc_cfg.svh"
// What this block does
// - Reset opcode aborts everything, restores known state
// - Feature reads answered during reset recovery
// - Reset clears write enable latch, sets busy, refreshes ECC, clears mode
// - Block lock bits survive reset command
// - Write enable opcode sets the latch
// - Write disable opcode clears the latch
// - Page read takes 24-bit row address
// - Page read busy for array read time
// - Single-line cache read: column, eight dummy clocks
// - Cache bytes MSB first, falling edge
// - Column advances per byte, chip select ends
// - Cache reads stream bytes from given column
// - Plane select bit of column ignored
// - x2 read drives two lines
// - x4 read drives four lines
// - Dual/quad IO reads take address on lanes
// - Program load writes data into cache
// - Random load overwrites only addressed bytes
// - Permanent lock takes three address bytes
// - Cache last opcode ends cache read
// - Inputs latched on rising serial clock
// - Busy bit high during transfer, then low
module snc_decoder
  import snc_pkg::*;
#(
  parameter logic [23:0] RST_CYC = 24'(`SNC_RST_CYC),
  parameter logic [23:0] PRG_CYC = 24'(`SNC_PRG_CYC),
  parameter logic [23:0] ERS_CYC = 24'(`SNC_ERS_CYC)
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  input wire logic [1:0] ecc_stat_i,
  output logic arr_start_o,
  output snc_arr_op_t arr_op_o,
  output logic [15:0] arr_row_o,
  output logic oip_o,
  output logic wel_o,
  output logic [7:0] cfg_o,
  output logic [7:0] lock_o
);

  // Link side, clocked by the serial clock, cleared while deselected
  snc_state_t state_r;
  logic [4:0] cnt_r;
  logic [2:0] lanes_r;
  logic [23:0] sh_r;
  logic [7:0] opc_r;
  logic [11:0] col_r;
  logic [7:0] fa_r;
  logic [4:0] abits_r;
  logic [4:0] dbits_r;
  logic [2:0] dlane_r;
  logic out_r;
  logic nodata_r;
  logic feat_r;
  logic load_r;

  logic [7:0] cache_mem [0:2175];

  logic [4:0] cnt_nxt;
  logic [23:0] sh_nxt;
  logic [7:0] op_w;
  logic byte_end;

  logic d_known;
  logic d_immed;
  logic d_nodata;
  logic d_out;
  logic d_feat;
  logic d_load;
  logic [4:0] d_abits;
  logic [4:0] d_dbits;
  logic [2:0] d_alane;
  logic [2:0] d_dlane;

  snc_evt_t ev_r;
  logic ev_tgl_r;
  snc_feat_t fs1_r;
  snc_feat_t fs2_r;
  snc_feat_t fs3_r;
  snc_feat_t fst_r;

  logic fire_opc;
  logic fire_addr;
  logic fire_data;
  logic [7:0] stat_r;

  assign cnt_nxt = cnt_r + {2'h0, lanes_r};
  assign op_w = {sh_r[6:0], io_i[0]};
  assign byte_end = (cnt_nxt[2:0] == 3'h0);

  // Lane-wide input shift
  always_comb begin
    case (lanes_r)
      3'h4: sh_nxt = {sh_r[19:0], io_i[3:0]};
      3'h2: sh_nxt = {sh_r[21:0], io_i[1:0]};
      default: sh_nxt = {sh_r[22:0], io_i[0]};
    endcase
  end

  // Opcode decode: phase lengths and lane widths
  always_comb begin
    d_known = 1'b1;
    d_immed = 1'b0;
    d_nodata = 1'b0;
    d_out = 1'b0;
    d_feat = 1'b0;
    d_load = 1'b0;
    d_abits = `SNC_COL_BITS;
    d_dbits = 5'h00;
    d_alane = 3'h1;
    d_dlane = 3'h1;
    case (op_w)
      `SNC_OP_RESET, `SNC_OP_WR_EN, `SNC_OP_WR_DIS, `SNC_OP_CACHE_LAST: begin
        d_immed = 1'b1;
      end
      `SNC_OP_GET_FEAT: begin
        d_abits = `SNC_FA_BITS;
        d_out = 1'b1;
        d_feat = 1'b1;
      end
      `SNC_OP_SET_FEAT: begin
        d_abits = `SNC_FA_BITS;
        d_feat = 1'b1;
      end
      `SNC_OP_PAGE_READ, `SNC_OP_PROG_EXEC, `SNC_OP_ERASE, `SNC_OP_PERM_LOCK: begin
        d_abits = `SNC_ROW_BITS;
        d_nodata = 1'b1;
      end
      `SNC_OP_RD_X1, `SNC_OP_RD_X1_FAST: begin
        d_dbits = `SNC_DUMMY1_BITS;
        d_out = 1'b1;
      end
      `SNC_OP_RD_X2: begin
        d_dbits = `SNC_DUMMY1_BITS;
        d_dlane = 3'h2;
        d_out = 1'b1;
      end
      `SNC_OP_RD_X4: begin
        d_dbits = `SNC_DUMMY1_BITS;
        d_dlane = 3'h4;
        d_out = 1'b1;
      end
      `SNC_OP_RD_DIO: begin
        d_dbits = `SNC_DUMMY1_BITS;
        d_alane = 3'h2;
        d_dlane = 3'h2;
        d_out = 1'b1;
      end
      `SNC_OP_RD_QIO: begin
        d_dbits = `SNC_DUMMY2_BITS;
        d_alane = 3'h4;
        d_dlane = 3'h4;
        d_out = 1'b1;
      end
      `SNC_OP_LOAD_X1, `SNC_OP_RLOAD_X1: begin
        d_load = 1'b1;
      end
      `SNC_OP_LOAD_X4, `SNC_OP_RLOAD_X4: begin
        d_load = 1'b1;
        d_dlane = 3'h4;
      end
      default: d_known = 1'b0;
    endcase
  end

  // Command sequencer: advances on the rising edge; opcode, address and input data are sampled there, dummy and output phases sample nothing
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      state_r <= SNC_ST_OPC;
      cnt_r <= 5'h00;
      lanes_r <= 3'h1;
      sh_r <= 24'h000000;
      opc_r <= 8'h00;
      col_r <= 12'h000;
      fa_r <= 8'h00;
      abits_r <= 5'h00;
      dbits_r <= 5'h00;
      dlane_r <= 3'h1;
      out_r <= 1'b0;
      nodata_r <= 1'b0;
      feat_r <= 1'b0;
      load_r <= 1'b0;
    end else begin
      unique case (state_r)
        SNC_ST_OPC: begin
          sh_r <= sh_nxt;
          cnt_r <= cnt_nxt;
          if (cnt_nxt == `SNC_OPC_BITS) begin
            opc_r <= op_w;
            cnt_r <= 5'h00;
            abits_r <= d_abits;
            dbits_r <= d_dbits;
            dlane_r <= d_dlane;
            out_r <= d_out;
            nodata_r <= d_nodata;
            feat_r <= d_feat;
            load_r <= d_load;
            lanes_r <= d_alane;
            state_r <= (!d_known || d_immed) ? SNC_ST_IGN : SNC_ST_ADDR;
          end
        end
        SNC_ST_ADDR: begin
          sh_r <= sh_nxt;
          cnt_r <= cnt_nxt;
          if (cnt_nxt == abits_r) begin
            cnt_r <= 5'h00;
            col_r <= sh_nxt[11:0];
            fa_r <= sh_nxt[7:0];
            if (dbits_r != 5'h00) begin
              state_r <= SNC_ST_DUMMY;
            end else if (nodata_r) begin
              state_r <= SNC_ST_IGN;
            end else begin
              lanes_r <= dlane_r;
              state_r <= out_r ? SNC_ST_DOUT : SNC_ST_DIN;
            end
          end
        end
        SNC_ST_DUMMY: begin
          cnt_r <= cnt_nxt;
          if (cnt_nxt == dbits_r) begin
            cnt_r <= 5'h00;
            lanes_r <= dlane_r;
            state_r <= SNC_ST_DOUT;
          end
        end
        SNC_ST_DIN: begin
          sh_r <= sh_nxt;
          cnt_r <= {2'h0, cnt_nxt[2:0]};
          if (byte_end) begin
            col_r <= col_r + 12'h001;
            if (feat_r) begin
              state_r <= SNC_ST_IGN;
            end
          end
        end
        SNC_ST_DOUT: begin
          cnt_r <= {2'h0, cnt_nxt[2:0]};
          if (byte_end) begin
            col_r <= col_r + 12'h001;
          end
        end
        SNC_ST_IGN: begin
          cnt_r <= 5'h00;
        end
      endcase
    end
  end

  // Cache writes touch only the addressed bytes
  always_ff @(posedge sck_i) begin
    if (state_r == SNC_ST_DIN && load_r && byte_end && col_r < `SNC_CACHE_BYTES) begin
      cache_mem[col_r] <= sh_nxt[7:0];
    end
  end

  assign fire_opc = (state_r == SNC_ST_OPC) && (cnt_nxt == `SNC_OPC_BITS) && d_immed;
  assign fire_addr = (state_r == SNC_ST_ADDR) && (cnt_nxt == abits_r) && nodata_r;
  assign fire_data = (state_r == SNC_ST_DIN) && feat_r && byte_end;

  // Event word is held stable and announced by a toggle to the system side
  always_ff @(posedge sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ev_r <= '0;
      ev_tgl_r <= 1'b0;
    end else if (!cs_n_i) begin
      if (fire_opc) begin
        ev_r <= '{opc: op_w, addr: 24'h000000, data: 8'h00};
        ev_tgl_r <= ~ev_tgl_r;
      end else if (fire_addr) begin
        ev_r <= '{opc: opc_r, addr: sh_nxt, data: 8'h00};
        ev_tgl_r <= ~ev_tgl_r;
      end else if (fire_data) begin
        ev_r <= '{opc: opc_r, addr: {16'h0000, fa_r}, data: sh_nxt[7:0]};
        ev_tgl_r <= ~ev_tgl_r;
      end
    end
  end

  // Feature bytes into the link domain; a bit moves once stages two and three agree
  always_ff @(posedge sck_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fs1_r <= '0;
      fs2_r <= '0;
      fs3_r <= '0;
      fst_r <= '0;
    end else begin
      fs1_r <= '{lock: lock_o, cfg: cfg_o, stat: stat_r};
      fs2_r <= fs1_r;
      fs3_r <= fs2_r;
      fst_r <= (~(fs2_r ^ fs3_r) & fs2_r) | ((fs2_r ^ fs3_r) & fst_r);
    end
  end

  logic [7:0] feat_byte;
  logic [7:0] rd_byte;
  logic [7:0] rd_shl;

  always_comb begin
    case (fa_r)
      `SNC_FA_LOCK: feat_byte = fst_r.lock;
      `SNC_FA_CFG: feat_byte = fst_r.cfg;
      `SNC_FA_STATUS: feat_byte = fst_r.stat;
      default: feat_byte = 8'h00;
    endcase
    if (feat_r) begin
      rd_byte = feat_byte;
    end else if (col_r < `SNC_CACHE_BYTES) begin
      rd_byte = cache_mem[col_r];
    end else begin
      rd_byte = 8'hFF;
    end
    rd_shl = rd_byte << cnt_r[2:0];
  end

  // Output lanes change on the falling edge, MSB first
  always_ff @(negedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end else if (state_r == SNC_ST_DOUT) begin
      case (lanes_r)
        3'h4: begin
          io_o <= rd_shl[7:4];
          io_oe_o <= 4'hF;
        end
        3'h2: begin
          io_o <= {2'h0, rd_shl[7:6]};
          io_oe_o <= 4'h3;
        end
        default: begin
          io_o <= {2'h0, rd_shl[7], 1'b0};
          io_oe_o <= 4'h2;
        end
      endcase
    end else begin
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end
  end

  // System side
  logic et1_r;
  logic et2_r;
  logic et3_r;
  logic seen_r;
  logic new_ev;
  logic [1:0] ecc_r;
  logic [23:0] busy_r;

  assign new_ev = (et2_r == et3_r) && (et2_r != seen_r);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      et1_r <= 1'b0;
      et2_r <= 1'b0;
      et3_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      et1_r <= ev_tgl_r;
      et2_r <= et1_r;
      et3_r <= et2_r;
      if (et2_r == et3_r) begin
        seen_r <= et2_r;
      end
    end
  end

  // Busy timer and the array command it stands for
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      busy_r <= 24'h000000;
      oip_o <= 1'b0;
      arr_start_o <= 1'b0;
      arr_op_o <= SNC_ARR_NONE;
      arr_row_o <= 16'h0000;
    end else begin
      arr_start_o <= 1'b0;
      if (busy_r != 24'h000000) begin
        busy_r <= busy_r - 24'h000001;
        if (busy_r == 24'h000001) begin
          oip_o <= 1'b0;
        end
      end
      if (new_ev) begin
        arr_row_o <= ev_r.addr[15:0];
        if (ev_r.opc == `SNC_OP_RESET) begin
          arr_op_o <= SNC_ARR_ABORT;
          arr_start_o <= 1'b1;
          busy_r <= RST_CYC;
          oip_o <= 1'b1;
        end else if (!oip_o) begin
          arr_start_o <= 1'b1;
          oip_o <= 1'b1;
          case (ev_r.opc)
            `SNC_OP_PAGE_READ: begin
              arr_op_o <= SNC_ARR_READ;
              busy_r <= 24'(`SNC_RD_CYC);
            end
            `SNC_OP_CACHE_LAST: begin
              arr_op_o <= SNC_ARR_COPY;
              busy_r <= 24'(`SNC_CPY_CYC);
            end
            `SNC_OP_PERM_LOCK: begin
              arr_op_o <= SNC_ARR_LOCK;
              busy_r <= PRG_CYC;
            end
            `SNC_OP_PROG_EXEC, `SNC_OP_ERASE: begin
              if (wel_o) begin
                arr_op_o <= (ev_r.opc == `SNC_OP_ERASE) ? SNC_ARR_ERASE : SNC_ARR_PROG;
                busy_r <= (ev_r.opc == `SNC_OP_ERASE) ? ERS_CYC : PRG_CYC;
              end else begin
                arr_start_o <= 1'b0;
                oip_o <= 1'b0;
              end
            end
            default: begin
              arr_start_o <= 1'b0;
              oip_o <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Write enable latch
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wel_o <= 1'b0;
    end else if (new_ev) begin
      if (ev_r.opc == `SNC_OP_WR_EN) begin
        wel_o <= 1'b1;
      end else if (ev_r.opc == `SNC_OP_WR_DIS || ev_r.opc == `SNC_OP_RESET) begin
        wel_o <= 1'b0;
      end
    end
  end

  // Feature registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ecc_r <= 2'h0;
      cfg_o <= `SNC_CFG_RST;
      lock_o <= `SNC_LOCK_RST;
    end else if (new_ev) begin
      if (ev_r.opc == `SNC_OP_RESET) begin
        ecc_r <= ecc_stat_i;
        cfg_o[`SNC_CFG_MODE_HI:0] <= 3'h0;
      end else if (ev_r.opc == `SNC_OP_SET_FEAT) begin
        if (ev_r.addr[7:0] == `SNC_FA_LOCK) begin
          lock_o <= ev_r.data;
        end else if (ev_r.addr[7:0] == `SNC_FA_CFG) begin
          cfg_o <= ev_r.data;
        end
      end
    end
  end

  always_comb begin
    stat_r = 8'h00;
    stat_r[`SNC_ST_OIP] = oip_o;
    stat_r[`SNC_ST_WEL] = wel_o;
    stat_r[`SNC_ST_ECC_HI:`SNC_ST_ECC_LO] = ecc_r;
  end

endmodule

// file: snc_decoder_sva.sv
`timescale 1ns/1ps
module snc_decoder_sva
  import snc_pkg::*;
#(
  parameter logic [23:0] RST_CYC = 24'h000014
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_oe_o,
  input wire logic arr_start_o,
  input wire snc_arr_op_t arr_op_o,
  input wire logic oip_o,
  input wire logic wel_o,
  input wire logic [7:0] cfg_o,
  input wire logic [7:0] lock_o
);
  logic [23:0] busy_cnt_r;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Busy length since the last start pulse
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      busy_cnt_r <= 24'h000000;
    end else if (arr_start_o) begin
      busy_cnt_r <= 24'h000001;
    end else if (oip_o) begin
      busy_cnt_r <= busy_cnt_r + 24'h000001;
    end
  end
  sequence abort_s;
    arr_start_o && arr_op_o == SNC_ARR_ABORT;
  endsequence
  sequence mode_cleared_s;
    ##[0:3] (!wel_o && cfg_o[2:0] == 3'h0);
  endsequence
  busy_rise_a: assert property ($rose(oip_o) |-> arr_start_o)
    else $error("busy rose without start");
  start_pulse_a: assert property (arr_start_o |=> !arr_start_o)
    else $error("start pulse too long");
  reset_busy_a: assert property ($fell(oip_o) && arr_op_o == SNC_ARR_ABORT |->
    busy_cnt_r inside {[RST_CYC - 24'h000002:RST_CYC + 24'h000002]})
    else $error("reset recovery length wrong");
  read_busy_a: assert property ($fell(oip_o) && arr_op_o == SNC_ARR_READ |->
    busy_cnt_r inside {[24'h0009C2:24'h0009C6]})
    else $error("array read length wrong");
  reset_clear_a: assert property (abort_s |-> mode_cleared_s)
    else $error("reset left latch or mode set");
  lock_keep_a: assert property (abort_s |=> $stable(lock_o) [*3])
    else $error("lock changed on reset");
  wel_gate_a: assert property (arr_start_o && arr_op_o inside {SNC_ARR_PROG,
    SNC_ARR_ERASE} |-> wel_o)
    else $error("program or erase without latch");
  oe_idle_a: assert property (cs_n_i |-> io_oe_o == 4'h0)
    else $error("driving while deselected");
  oe_width_a: assert property (io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal lane enable");
endmodule

bind snc_decoder snc_decoder_sva #(.RST_CYC(RST_CYC)) u_sva (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o),
  .arr_start_o(arr_start_o), .arr_op_o(arr_op_o), .oip_o(oip_o), .wel_o(wel_o),
  .cfg_o(cfg_o), .lock_o(lock_o)
);

// file: snc_host.sv
`timescale 1ns/1ps
module snc_host (
  input wire logic [3:0] io_w_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] hio_o,
  output logic [3:0] hoe_o
);
  logic m3 = 1'b0;
  initial begin
    sck_o = 1'b0;
    hio_o = 4'h0;
    hoe_o = 4'h0;
    // Deselect after time zero so the link state sees a real clearing edge
    #1 cs_n_o = 1'b1;
  end
  task automatic start(input logic m);
    #3.3;
    m3 = m;
    sck_o = m;
    #32;
    cs_n_o = 1'b0;
    #32;
  endtask
  // Lanes change on the falling edge, the wire is sampled on the rising one
  task automatic clk(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] s);
    sck_o = 1'b0;
    hio_o = v;
    hoe_o = oe;
    #32;
    sck_o = 1'b1;
    s = io_w_i;
    #32;
  endtask
  task automatic send(input logic [31:0] v, input int n, input int w);
    logic [3:0] s;
    for (int i = n - w; i >= 0; i -= w) begin
      clk(4'(v >> i), 4'((1 << w) - 1), s);
    end
  endtask
  task automatic get(output logic [7:0] b, input int w);
    logic [3:0] s;
    b = 8'h00;
    for (int i = 0; i < 8 / w; i++) begin
      clk(4'h0, 4'h0, s);
      b = (w == 1) ? {b[6:0], s[1]} : (w == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
    end
  endtask
  task automatic stop();
    sck_o = m3;
    hoe_o = 4'h0;
    #32;
    cs_n_o = 1'b1;
    #64;
  endtask
endmodule

// file: tb_serial_nand_command_decoder.sv
`timescale 1ns/1ps
module tb_serial_nand_command_decoder;
  import snc_pkg::*;
  logic mclk, sys_rst, sck, cs_n, arr_start, operation_in_progress, write_enable_latch;
  logic flip = 1'b0;
  logic [3:0] io_w, io_o, io_oe, hio, hoe;
  logic [1:0] ecc;
  logic [7:0] cfg, lock, b, lv, cv;
  logic [15:0] arr_row, last_row, c;
  snc_arr_op_t arr_op, last_op;
  logic [7:0] cm [0:4095];
  int n_errors, samples_checked, n_starts, k;
  int aw [6] = '{1, 1, 1, 1, 2, 4};
  int dn [6] = '{8, 8, 8, 8, 8, 16};
  int ow [6] = '{1, 1, 2, 4, 2, 4};
  logic [7:0] rop [6] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
  logic [7:0] lop [4] = '{8'h02, 8'h32, 8'h84, 8'h34};
  // Released lanes toggle so a stale level never passes for data
  assign io_w = (io_oe & io_o) | (~io_oe & hoe & hio) | (~io_oe & ~hoe & {4{flip}});
  snc_decoder #(.RST_CYC(24'h0007D0), .PRG_CYC(24'h000014), .ERS_CYC(24'h000014)) dut (
    .mclk_i(mclk), .sys_rst_i(sys_rst), .sck_i(sck), .cs_n_i(cs_n), .io_i(io_w),
    .io_o(io_o), .io_oe_o(io_oe), .ecc_stat_i(ecc), .arr_start_o(arr_start),
    .arr_op_o(arr_op), .arr_row_o(arr_row), .oip_o(operation_in_progress), .wel_o(write_enable_latch), .cfg_o(cfg),
    .lock_o(lock));
  snc_host host (.io_w_i(io_w), .sck_o(sck), .cs_n_o(cs_n), .hio_o(hio), .hoe_o(hoe));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    flip <= ~flip;
    if (arr_start === 1'b1) begin
      n_starts <= n_starts + 1;
      last_op <= arr_op;
      last_row <= arr_row;
    end
  end
  task automatic results();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] expb(input int a);
    return (a >= 2176) ? 8'hFF : cm[a];
  endfunction
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int n);
    host.start(1'($urandom));
    host.send({24'h0, op}, 8, 1);
    host.send(a, n, 1);
    host.stop();
    repeat (12) @(posedge mclk);
  endtask
  task automatic getf(input logic [7:0] fa);
    host.start(1'($urandom));
    host.send({16'h0, 8'h0F, fa}, 16, 1);
    host.get(b, 1);
    host.stop();
  endtask
  task automatic run(input logic [7:0] op, input snc_arr_op_t e, input int n);
    logic [23:0] a;
    a = 24'($urandom);
    k = n_starts;
    cmd(op, 32'(a), n);
    chk(n_starts, k + 1);
    chk(last_op, e);
    if (n > 0) chk(last_row, a[15:0]);
  endtask
  task automatic idle();
    for (int i = 0; i < 4000 && operation_in_progress !== 1'b0; i++) @(posedge mclk);
    chk(operation_in_progress, 0);
  endtask
  task automatic load(input logic [7:0] op, input int w, input logic [15:0] col, input int n);
    logic [7:0] d;
    host.start(1'($urandom));
    host.send({24'h0, op}, 8, 1);
    host.send({16'h0, col}, 16, 1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      cm[int'(col[11:0]) + i] = d;
      host.send({24'h0, d}, 8, w);
    end
    host.stop();
  endtask
  task automatic rd(input logic [7:0] op, input int a, input int d, input int w,
    input logic [15:0] col, input int n);
    host.start(1'($urandom));
    host.send({24'h0, op}, 8, 1);
    host.send({16'h0, col}, 16, a);
    host.send(0, d, a);
    for (int i = 0; i < n; i++) begin
      host.get(b, w);
      chk(b, expb(int'(col[11:0]) + i));
    end
    chk(io_oe, (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hF);
    host.stop();
  endtask
  initial begin
    #600000;
    n_errors++;
    results();
  end
  initial begin
    sys_rst = 1'b0;
    ecc = 2'h0;
    // A real rising edge so the link-side flops see their asynchronous clear
    #1 sys_rst = 1'b1;
    void'($urandom(25));
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
    chk(write_enable_latch, 0);
    chk(cfg, 8'h00);
    chk(lock, 8'h00);
    cmd(8'h10, 32'($urandom), 24);
    cmd(8'hD8, 32'($urandom), 24);
    chk(n_starts, 0);
    cmd(8'h06, 0, 0);
    chk(write_enable_latch, 1);
    getf(8'hC0);
    chk(b[1], 1);
    run(8'h10, SNC_ARR_PROG, 24);
    idle();
    run(8'hD8, SNC_ARR_ERASE, 24);
    idle();
    run(8'h2C, SNC_ARR_LOCK, 24);
    idle();
    run(8'h13, SNC_ARR_READ, 24);
    getf(8'hC0);
    chk(b[0], 1);
    k = n_starts;
    cmd(8'h13, 32'($urandom), 24);
    chk(n_starts, k);
    idle();
    cmd(8'h04, 0, 0);
    chk(write_enable_latch, 0);
    lv = 8'($urandom);
    cv = 8'($urandom) | 8'h05;
    cmd(8'h1F, {16'h0, 8'hA0, lv}, 16);
    cmd(8'h1F, {16'h0, 8'hB0, cv}, 16);
    chk(cfg, cv);
    getf(8'hA0);
    chk(b, lv);
    cmd(8'h06, 0, 0);
    @(posedge mclk);
    #1 ecc = 2'($urandom);
    run(8'hFF, SNC_ARR_ABORT, 0);
    chk(write_enable_latch, 0);
    chk(cfg, {cv[7:3], 3'h0});
    chk(lock, lv);
    getf(8'hC0);
    chk(b[0], 1);
    chk(b[5:4], ecc);
    idle();
    run(8'h13, SNC_ARR_READ, 24);
    run(8'hFF, SNC_ARR_ABORT, 0);
    idle();
    run(8'h3F, SNC_ARR_COPY, 0);
    idle();
    k = n_starts;
    cmd(8'h9F, 32'($urandom), 24);
    cmd(8'h06, 0, 0);
    chk(n_starts, k);
    chk(write_enable_latch, 1);
    c = 16'($urandom % 2000);
    for (int i = 0; i < 4; i++) begin
      load(lop[i], (i % 2 == 1) ? 4 : 1, (c + 16'(2 * i)) | {3'h0, 1'($urandom), 12'h0},
        8 - 2 * i);
    end
    for (int i = 0; i < 6; i++) begin
      rd(rop[i], aw[i], dn[i], ow[i], (c + 16'($urandom % 3)) | 16'h1000, 6);
    end
    load(8'h02, 1, 16'h087C, 4);
    rd(8'h03, 1, 8, 1, 16'h087E, 4);
    results();
  end
endmodule
